// ---- rtl/lts_serializer.sv ----
`timescale 1ns/1ps
module lts_serializer (
	input  wire logic              mclk,
	input  wire logic              reset_n,
	input  wire lts_pkg::lts_pins_t pins,
	output lts_pkg::lts_link_t     link
);
	import lts_pkg::*;

	lts_pins_t          pins_s1_q;
	lts_pins_t          pins_s2_q;
	logic               clk_prev_q;
	logic [2:0]         idx_q;
	logic [2:0]         idx_d;
	logic               fwd_q;
	logic               en_q;
	logic               bit_tick;
	logic               locked;
	logic [LANES-1:0]   lane_bit;

	// Two-flop synchronisers; only the second stage feeds logic
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			pins_s1_q <= '0;
			pins_s2_q <= '0;
		end else begin
			pins_s1_q <= pins;
			pins_s2_q <= pins_s1_q;
		end
	end

	wire clear_w   = !pins_s2_q.shutdown_clear_n;
	wire hold_w    = !reset_n || clear_w;
	wire rise_w    = pins_s2_q.pixel_clock_in && !clk_prev_q;
	wire fall_w    = !pins_s2_q.pixel_clock_in && clk_prev_q;
	wire cap_edge_w = pins_s2_q.edge_select_pin ? rise_w : fall_w;

	always_ff @(posedge mclk) begin
		if (hold_w) begin
			clk_prev_q <= 1'b0;
		end else begin
			clk_prev_q <= pins_s2_q.pixel_clock_in;
		end
	end

	lts_bit_timer u_bit_timer (
		.mclk       (mclk),
		.reset_n    (reset_n),
		.clear      (clear_w),
		.frame_edge (cap_edge_w),
		.bit_tick   (bit_tick),
		.locked     (locked)
	);

	// Slot index restarts at each capture; saturates so a late tick cannot wrap
	always_comb begin
		idx_d = idx_q;
		if (cap_edge_w) begin
			idx_d = BIT_FIRST;
		end else if (bit_tick && idx_q != BIT_LAST) begin
			idx_d = idx_q + BIT_STEP;
		end
	end

	always_ff @(posedge mclk) begin
		if (hold_w) begin
			idx_q <= BIT_FIRST;
		end else begin
			idx_q <= idx_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (hold_w) begin
			fwd_q <= 1'b0;
		end else begin
			fwd_q <= FWD_CLK_PATTERN[idx_d];
		end
	end

	// Enable follows lock, taken at a capture so the first frame is whole
	always_ff @(posedge mclk) begin
		if (hold_w || !locked) begin
			en_q <= 1'b0;
		end else if (cap_edge_w) begin
			en_q <= 1'b1;
		end
	end

	// Lane l bit b carries data[l*7+b]; the receiver uses the same fixed map
	for (genvar l = 0; l < LANES; l++) begin : g_lane
		logic [BITS_PER_LANE-1:0] sr_q;
		always_ff @(posedge mclk) begin
			if (hold_w) begin
				sr_q <= '0;
			end else if (cap_edge_w) begin
				sr_q <= pins_s2_q.data[l*BITS_PER_LANE +: BITS_PER_LANE];
			end else if (bit_tick) begin
				sr_q <= {1'b0, sr_q[BITS_PER_LANE-1:1]};
			end
		end
		assign lane_bit[l] = sr_q[0];
	end

	// Gated straight off the synchronised shutdown so the off state lands in two edges
	wire on_w = en_q && !clear_w;
	assign link.lane_p            = on_w ? lane_bit : '0;
	assign link.lane_n            = on_w ? ~lane_bit : '0;
	assign link.forwarded_clock_p = on_w && fwd_q;
	assign link.forwarded_clock_n = on_w && !fwd_q;
	assign link.drive_en          = on_w;

endmodule : lts_serializer

// ---- rtl/lts_pkg.sv ----
package lts_pkg;

	localparam int          LANES          = 4;
	localparam int          BITS_PER_LANE  = 7;
	localparam int          DATA_W         = LANES * BITS_PER_LANE;

	// Forwarded clock level per bit slot: low for slots 0..2, high for 3..6
	localparam logic [6:0]  FWD_CLK_PATTERN = 7'h78;
	localparam logic [2:0]  BIT_FIRST      = 3'h0;
	localparam logic [2:0]  BIT_LAST       = 3'h6;
	localparam logic [2:0]  BIT_STEP       = 3'h1;

	localparam logic [7:0]  PERIOD_ONE     = 8'h01;
	localparam logic [7:0]  PERIOD_MAX     = 8'hff;
	localparam logic [8:0]  BIT_MULT       = 9'h007;
	localparam logic [2:0]  LOCK_STABLE    = 3'h3;
	localparam logic [2:0]  STABLE_STEP    = 3'h1;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic              edge_select_pin;
		logic              shutdown_clear_n;
		logic              pixel_clock_in;
	} lts_pins_t;

	typedef struct packed {
		logic [LANES-1:0] lane_p;
		logic [LANES-1:0] lane_n;
		logic             forwarded_clock_p;
		logic             forwarded_clock_n;
		logic             drive_en;
	} lts_link_t;

endpackage : lts_pkg

// ---- rtl/lts_bit_timer.sv ----
`timescale 1ns/1ps
module lts_bit_timer (
	input  wire logic mclk,
	input  wire logic reset_n,
	input  wire logic clear,
	input  wire logic frame_edge,
	output logic      bit_tick,
	output logic      locked
);
	import lts_pkg::*;

	logic [7:0] cnt_q;
	logic [7:0] meas_q;
	logic [8:0] acc_q;
	logic [2:0] stable_q;

	wire        hold_w    = !reset_n || clear;
	wire        cnt_sat_w = (cnt_q == PERIOD_MAX);
	wire [8:0]  meas_w    = {1'b0, meas_q};
	wire [8:0]  cnt_w     = {1'b0, cnt_q};
	wire        near_w    = (cnt_w <= meas_w + 9'h001) && (cnt_w + 9'h001 >= meas_w);
	wire [8:0]  acc_sum_w = acc_q + BIT_MULT;
	wire        cross_w   = (acc_sum_w >= meas_w) && (meas_q != 8'h00);

	// Six ticks per measured period, the capture giving the seventh slot: a fractional divider standing in for the 7x PLL
	assign bit_tick = !hold_w && !frame_edge && cross_w;
	assign locked   = (stable_q >= LOCK_STABLE);

	always_ff @(posedge mclk) begin
		if (hold_w) begin
			cnt_q <= 8'h00;
		end else if (frame_edge) begin
			cnt_q <= PERIOD_ONE;
		end else if (!cnt_sat_w) begin
			cnt_q <= cnt_q + PERIOD_ONE;
		end
	end

	always_ff @(posedge mclk) begin
		if (hold_w) begin
			meas_q <= 8'h00;
		end else if (frame_edge) begin
			meas_q <= cnt_q;
		end
	end

	// Lock needs several periods agreeing within one cycle; a stopped clock drops it
	always_ff @(posedge mclk) begin
		if (hold_w || cnt_sat_w) begin
			stable_q <= 3'h0;
		end else if (frame_edge) begin
			if (!near_w) begin
				stable_q <= 3'h0;
			end else if (!locked) begin
				stable_q <= stable_q + STABLE_STEP;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (hold_w || frame_edge) begin
			acc_q <= 9'h000;
		end else if (cross_w) begin
			acc_q <= acc_sum_w - meas_w;
		end else begin
			acc_q <= acc_sum_w;
		end
	end

endmodule : lts_bit_timer

// ---- dv/lts_monitor.sv ----
`timescale 1ns/1ps
module lts_monitor (
	input wire logic               mclk,
	input wire logic               reset_n,
	input wire lts_pkg::lts_pins_t pins,
	input wire lts_pkg::lts_link_t link
);
	import lts_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	wire       fp = link.forwarded_clock_p;
	wire       en = link.drive_en;
	wire [3:0] b0 = {pins.data[21], pins.data[14], pins.data[7], pins.data[0]};
	chk_off_quiet: assert property (!en |-> link == '0) else $error("live when off");
	chk_lane_pair: assert property (en |-> link.lane_n == ~link.lane_p
		&& link.forwarded_clock_n == !fp) else $error("pair");
	chk_stop_fast: assert property ($fell(pins.shutdown_clear_n) |-> ##[1:2] link == '0)
		else $error("slow stop");
	chk_clear_hold: assert property ((!pins.shutdown_clear_n)[*3] |-> link == '0)
		else $error("not clear");
	chk_fwd_high: assert property ($rose(fp) |-> fp[*4] or ##[1:3] !en) else $error("high");
	chk_fwd_low: assert property ($fell(fp) && en |-> (!fp)[*3]) else $error("low");
	chk_fwd_rate: assert property ($rose(fp) |-> ##[7:9] ($rose(fp) || !en))
		else $error("rate");
	chk_slot0_word: assert property ($fell(fp) && en |-> link.lane_p == $past(b0, 4))
		else $error("word");
endmodule : lts_monitor

// ---- dv/lts_rx_model.sv ----
`timescale 1ns/1ps
module lts_rx_model (
	input  wire logic               mclk,
	input  wire lts_pkg::lts_link_t link,
	output logic [3:0]              first_q,
	output logic [3:0]              last_q,
	output logic [27:0]             word_q
);
	import lts_pkg::*;
	logic        fwd_q = 1'b0;
	logic [3:0]  prev_q;
	logic [2:0]  ph_q = 3'h0;
	logic [27:0] part_q = 28'h0;
	wire         start = fwd_q & ~link.forwarded_clock_p & link.drive_en;
	// Strobes for an 8-cycle link clock: slot k is read at edge ceil(8k/7)+1 after the fall
	wire         take  = start || ph_q >= 3'h2;
	wire [2:0]   slot  = start ? 3'h0 : ph_q - 3'h1;
	always_ff @(posedge mclk) begin
		fwd_q  <= link.forwarded_clock_p;
		prev_q <= link.lane_p;
		ph_q   <= (start || ph_q == 3'h0 || ph_q == 3'h7) ? {2'h0, start} : ph_q + 3'h1;
		if (start) begin
			first_q <= link.lane_p;
			last_q  <= prev_q;
			word_q  <= part_q;
		end
		if (take) begin
			for (int l = 0; l < LANES; l++) begin
				part_q[l * BITS_PER_LANE + slot] <= link.lane_p[l];
			end
		end
	end
endmodule : lts_rx_model

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
	import lts_pkg::*;
	logic        mclk = 1'b0;
	logic        reset_n = 1'b0;
	logic [2:0]  cnt = 3'h0;
	logic [27:0] w = 28'h0;
	logic        pclk = 1'b0;
	logic        es = 1'b1;
	logic        sd_n = 1'b1;
	logic [27:0] dat = 28'h0;
	logic [27:0] rx_word;
	wire lts_pins_t pins = {dat, es, sd_n, pclk};
	lts_link_t   link;
	logic [3:0]  first_q;
	logic [3:0]  last_q;
	int          n_mismatch = 0;
	int          checked = 0;
	int          cyc = 0;
	logic [27:0] tv [4] = '{28'h0000001, 28'h8000040, 28'hace1357, 28'hfffffff};
	always #25 mclk = ~mclk;
	lts_serializer dut (.mclk(mclk), .reset_n(reset_n), .pins(pins), .link(link));
	lts_rx_model rx (.mclk(mclk), .link(link), .first_q(first_q), .last_q(last_q),
		.word_q(rx_word));
	task automatic summarize();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : summarize
	// Data garbled around the unselected edge, so a wrong-edge capture shows
	always @(posedge mclk) begin
		cnt <= cnt + 3'h1;
		cyc <= cyc + 1;
		pclk <= es ^ cnt[2];
		dat <= (cnt == 3'h3 || cnt == 3'h4) ? ~w : w;
		if (cyc == 3000) begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic cmp_word(input logic [27:0] got, input logic [27:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t word got %h exp %h", $time, got, exp);
		end
	endtask : cmp_word
	task automatic wait_lock();
		repeat (200) if (link.drive_en !== 1'b1) @(negedge mclk);
		@(negedge mclk) cmp(11'(link.drive_en), 11'h1);
	endtask : wait_lock
	task automatic t_word(input logic [27:0] v);
		@(posedge mclk iff cnt == 3'h4) w <= v;
		repeat (24) @(posedge mclk);
		@(negedge mclk) cmp(11'(first_q), 11'({v[21], v[14], v[7], v[0]}));
		cmp(11'(last_q), 11'({v[27], v[20], v[13], v[6]}));
		cmp_word(rx_word, v);
	endtask : t_word
	task automatic t_off(input logic s);
		@(posedge mclk) sd_n <= 1'b0;
		es <= s;
		repeat (2) @(posedge mclk);
		@(negedge mclk) cmp(link, 11'h0);
		@(posedge mclk) sd_n <= 1'b1;
		wait_lock();
	endtask : t_off
	initial begin
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
		@(negedge mclk) cmp(link, 11'h0);
		wait_lock();
		for (int k = 0; k < 2; k++) begin
			foreach (tv[i]) t_word(tv[i]);
			t_off(k[0]);
		end
		summarize();
	end
endmodule : tb
bind lts_serializer lts_monitor mon (.mclk(mclk), .reset_n(reset_n), .pins(pins), .link(link));
